// File: include/e1_perf_pkg.sv
package e1_perf_pkg;

  // register offsets within the receive status page
  localparam logic [4:0] OFS_OVERFLOW_LATCH  = 5'h16;
  localparam logic [4:0] OFS_FRAME_SYNC_LOSS = 5'h17;
  localparam logic [4:0] OFS_ALIGN_BIT_ERR   = 5'h18;
  localparam logic [4:0] OFS_REMOTE_ALARM    = 5'h19;
  localparam logic [4:0] OFS_ERRORED_ALIGN   = 5'h1a;
  localparam logic [4:0] OFS_ALARM_LATCH     = 5'h1b;
  localparam logic [4:0] OFS_VIOLATION_HI    = 5'h1c;
  localparam logic [4:0] OFS_VIOLATION_LO    = 5'h1d;
  localparam logic [4:0] OFS_CHECKSUM_HI     = 5'h1e;
  localparam logic [4:0] OFS_CHECKSUM_LO     = 5'h1f;

  // overflow latch bit positions
  localparam int OVF_FRAME_SYNC_LOSS = 4;
  localparam int OVF_ALIGN_BIT_ERR   = 3;
  localparam int OVF_ERRORED_ALIGN   = 2;
  localparam int OVF_VIOLATION       = 1;
  localparam int OVF_CHECKSUM        = 0;

  // alarm latch bit positions
  localparam int ALM_FAR_END      = 7;
  localparam int ALM_ALL_ONES     = 6;
  localparam int ALM_SLOT16       = 5;
  localparam int ALM_SIGNAL_ABSENT = 4;
  localparam int ALM_AUX_PATTERN  = 3;
  localparam int ALM_MULTIFRAME   = 2;
  localparam int ALM_SLIP         = 1;

  // remote-alarm/crc status bit positions
  localparam int RAC_WINDOW = 1;
  localparam int RAC_LONG   = 0;

  // counter widths
  localparam int CHECKSUM_W  = 10;
  localparam int VIOLATION_W = 16;

  // values after reset
  localparam logic [7:0]  RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  // timing
  localparam int CLK_PERIOD_NS  = 4;
  localparam int FRAME_US       = 125;
  localparam int RUN_MIN_MS     = 10;
  localparam int RUN_MAX_MS     = 450;
  localparam int NS_PER_MS      = 1000000;
  // least time rounds up, longest time rounds down
  localparam int RUN_MIN_CYCLES = (RUN_MIN_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RUN_MAX_CYCLES = (RUN_MAX_MS * NS_PER_MS) / CLK_PERIOD_NS;
  localparam int RUN_CNT_W      = 27;

  // received-line events, all synchronous to clk
  typedef struct packed {
    logic       frameTick;      // one pulse per 125 us receive frame
    logic       basicSyncLost;  // level: basic frame alignment absent
    logic       fasCheck;       // pulse: an alignment word was checked
    logic [2:0] fasBitErrors;   // bit errors in that word, valid with fasCheck
    logic       lineViolation;  // pulse: bipolar violation
    logic       crcMismatch;    // pulse: submultiframe crc disagreed
    logic       remoteAlarmBit; // level: received remote alarm bit
    logic       eBitLow;        // level: received e bits low
    logic       allOnes;        // level/pulse: all-ones alarm
    logic       slot16AllOnes;  // level/pulse: slot 16 all ones
    logic       signalAbsent;   // level/pulse: line signal lost
    logic       auxPattern;     // level/pulse: auxiliary pattern seen
    logic       multiframeAlarm; // level/pulse: multiframe alarm
    logic       elasticSlip;    // pulse: elastic buffer slipped
  } line_events_s;

  // run qualification states, gray coded along the path
  typedef enum logic [1:0] {
    RUN_IDLE  = 2'b00,
    RUN_SHORT = 2'b01,
    RUN_QUAL  = 2'b11,
    RUN_LONG  = 2'b10
  } run_state_e;

endpackage : e1_perf_pkg

// File: rtl/e1_rx_perf_monitor_status.sv
`timescale 1ns/1ps
// Summary of operation
// - sync-loss counter counts frames without alignment
// - sync-loss counter clears on alignment loss
// - alignment bit error total in eight bits
// - window flag: run 10-450 ms, clear-on-read
// - long flag high while run exceeds 10 ms
// - errored alignment word counter, once per word
// - latch bit 7 on remote alarm
// - latch bit 6 on all-ones alarm
// - latch bit 5 on slot 16 all-ones
// - latch bit 4 on signal loss
// - latch bit 3 on auxiliary pattern
// - latch bit 2 on multiframe alarm
// - latch bit 1 on slip, bit 0 unused
// - latch bits sticky until latch is read
// - 16-bit violation counter at 1CH/1DH
// - 10-bit crc counter at 1EH/1FH
// - overflow flags latch, cleared on read
module e1_rx_perf_monitor_status
  import e1_perf_pkg::*;
#(
  parameter int RUN_MIN = RUN_MIN_CYCLES, // shorten in simulation
  parameter int RUN_MAX = RUN_MAX_CYCLES  // shorten in simulation
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // received line events
  input  wire line_events_s lineEvents,
  // processor port
  input  wire logic [4:0]   cpuAddr,
  input  wire logic         cpuRead,
  input  wire logic         cpuWrite,
  input  wire logic [7:0]   cpuWriteData,
  output logic [7:0]        cpuReadData,
  output logic              cpuReadValid
);

  // add with carry out, shared by every counter
  function automatic logic [16:0] addCarry(input logic [15:0] value,
                                           input logic [15:0] inc);
    addCarry = {1'b0, value} + {1'b0, inc};
  endfunction : addCarry

  // true when the processor reads the given offset this cycle
  function automatic logic readOf(input logic [4:0] ofs);
    readOf = cpuRead && (cpuAddr == ofs);
  endfunction : readOf

  // counters
  logic [7:0]             frameSyncLossCount;     // frame periods out of alignment
  logic [7:0]             next_frameSyncLossCount;
  logic [7:0]             alignBitErrorCount;     // bit errors in alignment words
  logic [7:0]             next_alignBitErrorCount;
  logic [7:0]             erroredAlignCount;      // errored alignment words
  logic [7:0]             next_erroredAlignCount;
  logic [VIOLATION_W-1:0] violationCount;         // bipolar violations
  logic [VIOLATION_W-1:0] next_violationCount;
  logic [CHECKSUM_W-1:0]  checksumCount;          // crc-4 errors
  logic [CHECKSUM_W-1:0]  next_checksumCount;
  logic                   syncLostLast;           // alignment state one cycle ago
  logic [4:0]             overflowSet;            // wrap events this cycle

  // carries computed once, read by counters and overflow latch
  logic [16:0] sumFrameSync;
  logic [16:0] sumAlignBits;
  logic [16:0] sumErrored;
  logic [16:0] sumViolation;
  logic [16:0] sumChecksum;

  // counter next values
  always_comb begin
    sumFrameSync = addCarry({8'h00, frameSyncLossCount}, 16'h0001);
    sumAlignBits = addCarry({8'h00, alignBitErrorCount},
                            {13'h0000, lineEvents.fasBitErrors});
    sumErrored   = addCarry({8'h00, erroredAlignCount}, 16'h0001);
    sumViolation = addCarry(violationCount, 16'h0001);
    sumChecksum  = addCarry({6'h00, checksumCount}, 16'h0001);
    next_frameSyncLossCount = frameSyncLossCount;
    next_alignBitErrorCount = alignBitErrorCount;
    next_erroredAlignCount  = erroredAlignCount;
    next_violationCount     = violationCount;
    next_checksumCount      = checksumCount;
    overflowSet             = 5'h00;
    // entering loss of alignment restarts the count; it takes priority
    if (lineEvents.basicSyncLost && !syncLostLast) begin
      next_frameSyncLossCount = RESET_BYTE;
    end else if (lineEvents.basicSyncLost && lineEvents.frameTick) begin
      next_frameSyncLossCount = sumFrameSync[7:0];
      overflowSet[OVF_FRAME_SYNC_LOSS] = sumFrameSync[8];
    end
    // every checked word adds its error bits; a clean word adds zero
    if (lineEvents.fasCheck) begin
      next_alignBitErrorCount = sumAlignBits[7:0];
      overflowSet[OVF_ALIGN_BIT_ERR] = sumAlignBits[8];
    end
    // one step per bad word whatever the number of wrong bits
    if (lineEvents.fasCheck && (lineEvents.fasBitErrors != 3'h0)) begin
      next_erroredAlignCount = sumErrored[7:0];
      overflowSet[OVF_ERRORED_ALIGN] = sumErrored[8];
    end
    // bipolar violations
    if (lineEvents.lineViolation) begin
      next_violationCount = sumViolation[VIOLATION_W-1:0];
      overflowSet[OVF_VIOLATION] = sumViolation[VIOLATION_W];
    end
    // crc mismatches per submultiframe
    if (lineEvents.crcMismatch) begin
      next_checksumCount = sumChecksum[CHECKSUM_W-1:0];
      overflowSet[OVF_CHECKSUM] = sumChecksum[CHECKSUM_W];
    end
  end

  // counter registers; counters wrap and report it in the overflow latch
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      frameSyncLossCount <= RESET_BYTE;
      alignBitErrorCount <= RESET_BYTE;
      erroredAlignCount  <= RESET_BYTE;
      violationCount     <= RESET_WORD;
      checksumCount      <= '0;
      syncLostLast       <= 1'b0;
    end else begin
      frameSyncLossCount <= next_frameSyncLossCount;
      alignBitErrorCount <= next_alignBitErrorCount;
      erroredAlignCount  <= next_erroredAlignCount;
      violationCount     <= next_violationCount;
      checksumCount      <= next_checksumCount;
      syncLostLast       <= lineEvents.basicSyncLost;
    end
  end

  // sticky latches
  logic [4:0] overflowLatch;      // wrap flags, bits 4..0
  logic [4:0] next_overflowLatch;
  logic [7:1] alarmLatch;         // alarm flags, bit 0 does not exist
  logic [7:1] next_alarmLatch;
  logic [7:1] alarmSet;           // alarm events this cycle

  // latch next values; a new event beats the clear of the same read
  always_comb begin
    alarmSet[ALM_FAR_END]       = lineEvents.remoteAlarmBit;
    alarmSet[ALM_ALL_ONES]      = lineEvents.allOnes;
    alarmSet[ALM_SLOT16]        = lineEvents.slot16AllOnes;
    alarmSet[ALM_SIGNAL_ABSENT] = lineEvents.signalAbsent;
    alarmSet[ALM_AUX_PATTERN]   = lineEvents.auxPattern;
    alarmSet[ALM_MULTIFRAME]    = lineEvents.multiframeAlarm;
    alarmSet[ALM_SLIP]          = lineEvents.elasticSlip;
    // a persisting alarm level sets the flag again right after the read
    if (readOf(OFS_ALARM_LATCH)) begin
      next_alarmLatch = alarmSet;
    end else begin
      next_alarmLatch = alarmLatch | alarmSet;
    end
    if (readOf(OFS_OVERFLOW_LATCH)) begin
      next_overflowLatch = overflowSet;
    end else begin
      next_overflowLatch = overflowLatch | overflowSet;
    end
  end

  // latch registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      overflowLatch <= 5'h00;
      alarmLatch    <= 7'h00;
    end else begin
      overflowLatch <= next_overflowLatch;
      alarmLatch    <= next_alarmLatch;
    end
  end

  // remote alarm with continuous e-bit errors: run length timer
  run_state_e           runState;
  run_state_e           next_runState;
  logic [RUN_CNT_W-1:0] runCount;       // cycles the condition has held
  logic [RUN_CNT_W-1:0] next_runCount;
  logic                 windowFlag;     // status bit 1, clear-on-read
  logic                 next_windowFlag;
  logic                 longFlag;       // status bit 0, live level
  logic                 next_longFlag;
  logic                 runActive;      // condition present now
  logic                 windowEnd;      // run broke inside the window

  // timer next values
  always_comb begin
    runActive     = lineEvents.remoteAlarmBit && lineEvents.eBitLow;
    next_runState = runState;
    next_runCount = runCount;
    windowEnd     = 1'b0;
    case (runState)
      RUN_IDLE: begin
        // start counting on the first cycle of the condition
        if (runActive) begin
          next_runState = RUN_SHORT;
          next_runCount = RUN_CNT_W'(1);
        end
      end
      RUN_SHORT: begin
        // still under 10 ms; a break drops the run silently
        if (!runActive) begin
          next_runState = RUN_IDLE;
          next_runCount = '0;
        end else begin
          next_runCount = runCount + RUN_CNT_W'(1);
          if (runCount >= RUN_CNT_W'(RUN_MIN)) begin
            next_runState = RUN_QUAL;
          end
        end
      end
      RUN_QUAL: begin
        // past 10 ms; a break before 450 ms marks the window flag
        if (!runActive) begin
          next_runState = RUN_IDLE;
          next_runCount = '0;
          windowEnd     = 1'b1;
        end else begin
          next_runCount = runCount + RUN_CNT_W'(1);
          if (runCount >= RUN_CNT_W'(RUN_MAX - 1)) begin
            next_runState = RUN_LONG;
          end
        end
      end
      RUN_LONG: begin
        // too long for the window; counter parks to avoid wrap
        if (!runActive) begin
          next_runState = RUN_IDLE;
          next_runCount = '0;
        end
      end
      default: begin
        next_runState = RUN_IDLE;
        next_runCount = '0;
      end
    endcase
    // live level while the run lasts beyond 10 ms
    next_longFlag = runActive && ((runState == RUN_QUAL) || (runState == RUN_LONG)
                    || (next_runState == RUN_QUAL));
    // sticky window flag; the setting event wins over the read
    if (windowEnd) begin
      next_windowFlag = 1'b1;
    end else if (readOf(OFS_REMOTE_ALARM)) begin
      next_windowFlag = 1'b0;
    end else begin
      next_windowFlag = windowFlag;
    end
  end

  // timer registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      runState   <= RUN_IDLE;
      runCount   <= '0;
      windowFlag <= 1'b0;
      longFlag   <= 1'b0;
    end else begin
      runState   <= next_runState;
      runCount   <= next_runCount;
      windowFlag <= next_windowFlag;
      longFlag   <= next_longFlag;
    end
  end

  // read mux; registered so the port is glitch free
  logic [7:0] readMux;
  logic [7:0] next_cpuReadData;
  logic       next_cpuReadValid;

  // address decode; the page holds no writable bits at all
  always_comb begin
    readMux = 8'h00; // unmapped and unused bits read as zero
    if (cpuAddr == OFS_OVERFLOW_LATCH) begin
      readMux = {3'h0, overflowLatch};
    end else if (cpuAddr == OFS_FRAME_SYNC_LOSS) begin
      readMux = frameSyncLossCount;
    end else if (cpuAddr == OFS_ALIGN_BIT_ERR) begin
      readMux = alignBitErrorCount;
    end else if (cpuAddr == OFS_REMOTE_ALARM) begin
      readMux = {6'h00, windowFlag, longFlag};
    end else if (cpuAddr == OFS_ERRORED_ALIGN) begin
      readMux = erroredAlignCount;
    end else if (cpuAddr == OFS_ALARM_LATCH) begin
      readMux = {alarmLatch, 1'b0};
    end else if (cpuAddr == OFS_VIOLATION_HI) begin
      readMux = violationCount[15:8];
    end else if (cpuAddr == OFS_VIOLATION_LO) begin
      readMux = violationCount[7:0];
    end else if (cpuAddr == OFS_CHECKSUM_HI) begin
      readMux = {6'h00, checksumCount[9:8]};
    end else if (cpuAddr == OFS_CHECKSUM_LO) begin
      readMux = checksumCount[7:0];
    end
    // writes are accepted and dropped; the byte is never stored
    next_cpuReadValid = cpuRead && !cpuWrite;
    next_cpuReadData  = next_cpuReadValid ? readMux : cpuReadData; // data moves only with valid
  end

  // read port registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cpuReadData  <= RESET_BYTE;
      cpuReadValid <= 1'b0;
    end else begin
      cpuReadData  <= next_cpuReadData;
      cpuReadValid <= next_cpuReadValid;
    end
  end

  // write data has no destination on this status page
  logic unusedWrite;
  assign unusedWrite = ^cpuWriteData;

endmodule : e1_rx_perf_monitor_status

// File: verif/e1_line_source.sv
`timescale 1ns/1ps
// stand-in for the received line and framer front end
module e1_line_source
  import e1_perf_pkg::*;
(
  // clock
  input  wire logic    clk,
  // events toward the block
  output line_events_s lineEvents
);
  line_events_s levels; // standing line conditions
  // quiet line at time zero
  initial begin
    levels     = '0;
    lineEvents = '0;
  end
  // change standing conditions just after an edge
  task automatic set_levels(input line_events_s l);
    @(posedge clk);
    #1 levels = l;
    lineEvents = l;
  endtask : set_levels
  // one-cycle events over the standing conditions; an idle cycle follows
  task automatic pulse(input line_events_s p);
    @(posedge clk);
    #1 lineEvents = levels | p;
    @(posedge clk);
    #1 lineEvents = levels;
  endtask : pulse
endmodule : e1_line_source

// File: verif/e1_perf_asserts.sv
`timescale 1ns/1ps
// port-level checks for the receive status page
module e1_perf_asserts
  import e1_perf_pkg::*;
#(
  parameter int RUN_MIN = 20,  // qualifying run, cycles
  parameter int RUN_MAX = 100  // window ceiling, cycles
) (
  // clock and reset
  input wire logic         clk,
  input wire logic         reset,
  // received line events
  input wire line_events_s lineEvents,
  // processor port
  input wire logic [4:0]   cpuAddr,
  input wire logic         cpuRead,
  input wire logic         cpuWrite,
  input wire logic [7:0]   cpuWriteData,
  input wire logic [7:0]   cpuReadData,
  input wire logic         cpuReadValid
);
  logic [31:0] runLen;      // cycles the alarm/e-bit condition has held
  logic [31:0] next_runLen; // wide enough that no run in the bench wraps it
  logic [7:1]  latchPending;       // alarm events not yet reported by a latch read
  logic [7:1]  next_latchPending;
  logic        windowPending;      // in-window run ended, not yet reported
  logic        next_windowPending;
  // count consecutive cycles of alarm with low e bits
  always_comb begin
    next_runLen = (lineEvents.remoteAlarmBit && lineEvents.eBitLow) ? runLen + 32'h1 : 32'h0;
  end
  // register the run length
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      runLen        <= 32'h0;
      latchPending  <= 7'h00;
      windowPending <= 1'b0;
    end else begin
      runLen        <= next_runLen;
      latchPending  <= next_latchPending;
      windowPending <= next_windowPending;
    end
  end
  // mirror the sticky flags from the line events alone; an event beats the read
  always_comb begin
    next_latchPending = {lineEvents.remoteAlarmBit, lineEvents.allOnes,
                         lineEvents.slot16AllOnes, lineEvents.signalAbsent,
                         lineEvents.auxPattern, lineEvents.multiframeAlarm,
                         lineEvents.elasticSlip};
    if (!(cpuRead && cpuAddr == OFS_ALARM_LATCH)) begin
      next_latchPending = next_latchPending | latchPending;
    end
    next_windowPending = windowPending && !(cpuRead && cpuAddr == OFS_REMOTE_ALARM);
    // a run that breaks now, longer than the floor and shorter than the ceiling
    if (runLen > RUN_MIN && runLen < RUN_MAX && next_runLen == 32'h0) begin
      next_windowPending = 1'b1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // a plain read of one address
  sequence rd(a);
    cpuRead && !cpuWrite && cpuAddr == a;
  endsequence
  a_read_answer: assert property (cpuRead && !cpuWrite |=> cpuReadValid)
    else $error("read not answered next cycle");
  a_valid_cause: assert property (cpuReadValid |-> $past(cpuRead))
    else $error("read valid without a read");
  a_data_holds: assert property (!cpuReadValid |-> $stable(cpuReadData))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (
    cpuRead && !cpuWrite && cpuAddr < 5'h16 |=> cpuReadData == 8'h00)
    else $error("unmapped address read nonzero");
  a_crc_top_zero: assert property (rd(OFS_CHECKSUM_HI) |=> cpuReadData[7:2] == 6'h00)
    else $error("crc high byte unused bits set");
  a_status_top_zero: assert property (rd(OFS_REMOTE_ALARM) |=> cpuReadData[7:2] == 6'h00)
    else $error("alarm status unused bits set");
  a_latch_bit0_zero: assert property (rd(OFS_ALARM_LATCH) |=> !cpuReadData[0])
    else $error("alarm latch bit 0 set");
  a_slip_latched: assert property (
    rd(OFS_ALARM_LATCH) ##0 latchPending[ALM_SLIP] |=> cpuReadData[ALM_SLIP])
    else $error("slip not latched");
  a_far_end_latched: assert property (
    rd(OFS_ALARM_LATCH) ##0 latchPending[ALM_FAR_END]
    |=> cpuReadData[ALM_FAR_END])
    else $error("far end alarm not latched");
  a_latch_exact: assert property (
    rd(OFS_ALARM_LATCH) |=> cpuReadData[7:1] == $past(latchPending))
    else $error("alarm latch differs from events since last read");
  a_window_latched: assert property (
    rd(OFS_REMOTE_ALARM) ##0 windowPending |=> cpuReadData[RAC_WINDOW])
    else $error("window flag not reported");
  a_window_quiet: assert property (
    rd(OFS_REMOTE_ALARM) ##0 !windowPending |=> !cpuReadData[RAC_WINDOW])
    else $error("window flag set without an in-window run");
  a_long_flag_set: assert property (
    cpuRead && !cpuWrite && cpuAddr == OFS_REMOTE_ALARM && next_runLen > RUN_MIN + 3
    |=> cpuReadData[RAC_LONG])
    else $error("long run flag low during long run");
  a_long_flag_clear: assert property (
    rd(OFS_REMOTE_ALARM) ##0 (runLen == 0 && $past(runLen) == 0 && $past(runLen, 2) == 0)
    |=> !cpuReadData[RAC_LONG])
    else $error("long run flag high without run");
endmodule : e1_perf_asserts

bind e1_rx_perf_monitor_status e1_perf_asserts #(.RUN_MIN(RUN_MIN), .RUN_MAX(RUN_MAX)) u_chk (
  .clk(clk), .reset(reset), .lineEvents(lineEvents), .cpuAddr(cpuAddr),
  .cpuRead(cpuRead), .cpuWrite(cpuWrite), .cpuWriteData(cpuWriteData),
  .cpuReadData(cpuReadData), .cpuReadValid(cpuReadValid));

// File: verif/e1_rx_perf_monitor_status_test.sv
`timescale 1ns/1ps
// status page bench; a reference model tracks every count and flag
module e1_rx_perf_monitor_status_test;
  import e1_perf_pkg::*;
  localparam int RMIN = 20;  // short run bounds keep the run brief
  localparam int RMAX = 100;
  logic         clk, reset, cpuRead, cpuWrite, cpuReadValid;
  logic [4:0]   cpuAddr;
  logic [7:0]   cpuWriteData, cpuReadData;
  line_events_s lineEvents, ev;
  int errTotal, comparisons, fsl, abe, efa, bpv, crc, ovf, latch, win, longNow;
  int runs[$] = '{10, 50, 150}; // below, inside and beyond the window

  e1_rx_perf_monitor_status #(.RUN_MIN(RMIN), .RUN_MAX(RMAX)) i_dut (
    .clk(clk), .reset(reset), .lineEvents(lineEvents), .cpuAddr(cpuAddr),
    .cpuRead(cpuRead), .cpuWrite(cpuWrite), .cpuWriteData(cpuWriteData),
    .cpuReadData(cpuReadData), .cpuReadValid(cpuReadValid));
  e1_line_source i_line (.clk(clk), .lineEvents(lineEvents));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // model view of each register
  function automatic logic [7:0] expect_reg(input logic [4:0] a);
    case (a)
      OFS_OVERFLOW_LATCH:  return 8'(ovf);
      OFS_FRAME_SYNC_LOSS: return 8'(fsl);
      OFS_ALIGN_BIT_ERR:   return 8'(abe);
      OFS_REMOTE_ALARM:    return 8'(win * 2 + longNow);
      OFS_ERRORED_ALIGN:   return 8'(efa);
      OFS_ALARM_LATCH:     return 8'(latch);
      OFS_VIOLATION_HI:    return 8'(bpv >> 8);
      OFS_VIOLATION_LO:    return 8'(bpv);
      OFS_CHECKSUM_HI:     return 8'(crc >> 8);
      OFS_CHECKSUM_LO:     return 8'(crc);
      default:             return 8'h00;
    endcase
  endfunction : expect_reg
  // the one compare
  task automatic check(input string name, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      errTotal++;
      $display("wrong value %s expected %h seen %h", name, e, s);
    end
  endtask : check
  // counter step with wrap into the overflow latch
  task automatic bump(ref int c, input int w, input int b, input int n);
    c = c + n;
    if (c >= (1 << w)) begin
      c = c - (1 << w);
      ovf = ovf | (1 << b);
    end
  endtask : bump
  // write strobe; nothing should land
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 cpuAddr = a;
    cpuWrite = 1'b1;
    cpuWriteData = d;
    @(posedge clk);
    #1 cpuWrite = 1'b0;
  endtask : wr
  // read, compare, then apply clear-on-read to the model
  task automatic rd(input logic [4:0] a);
    logic [7:0] e;
    e = expect_reg(a);
    @(posedge clk);
    #1 cpuAddr = a;
    cpuRead = 1'b1;
    @(posedge clk);
    #1 cpuRead = 1'b0;
    check("read valid", 8'h01, {7'h00, cpuReadValid});
    check($sformatf("register %h", a), e, cpuReadData);
    if (a == OFS_OVERFLOW_LATCH) ovf = 0;
    if (a == OFS_REMOTE_ALARM) win = 0;
    if (a == OFS_ALARM_LATCH) latch = 0;
  endtask : rd
  // sweep of 10h..1fh, unmapped places included
  task automatic rd_all();
    for (int a = 16; a < 32; a++) rd(5'(a));
  endtask : rd_all
  // verdict
  task automatic tallyAndFinish();
    $display("comparisons %0d mismatches %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tallyAndFinish
  // hang guard
  initial begin
    #400000;
    errTotal++;
    $display("wrong value run time expected finish seen hang");
    tallyAndFinish();
  end
  // main sequence
  initial begin
    cpuAddr = 5'h00;
    cpuRead = 1'b0;
    cpuWrite = 1'b0;
    cpuWriteData = 8'h00;
    reset = 1'b1;
    void'($urandom(32'h4170));
    repeat (10) @(posedge clk);
    #1 reset = 1'b0;
    for (int a = 16; a < 32; a++) wr(5'(a), 8'(~a));
    rd_all();
    $display("test reset_and_writes done");
    ev = '0;
    ev.basicSyncLost = 1'b1;
    i_line.set_levels(ev);
    repeat (1200) begin
      ev = '0;
      case ($urandom % 4)
        0: begin
          ev.fasCheck = 1'b1;
          ev.fasBitErrors = 3'($urandom);
          bump(abe, 8, OVF_ALIGN_BIT_ERR, int'(ev.fasBitErrors));
          if (ev.fasBitErrors != 3'h0) bump(efa, 8, OVF_ERRORED_ALIGN, 1);
        end
        1: begin
          ev.lineViolation = 1'b1;
          bump(bpv, 16, OVF_VIOLATION, 1);
        end
        2: begin
          ev.crcMismatch = 1'b1;
          bump(crc, CHECKSUM_W, OVF_CHECKSUM, 1);
        end
        default: begin
          ev.frameTick = 1'b1;
          bump(fsl, 8, OVF_FRAME_SYNC_LOSS, 1);
        end
      endcase
      i_line.pulse(ev);
    end
    rd_all();
    rd_all();
    // aligned frames do not count; a fresh loss of alignment clears
    i_line.set_levels('0);
    ev = '0;
    ev.frameTick = 1'b1;
    i_line.pulse(ev);
    rd(OFS_FRAME_SYNC_LOSS);
    ev.basicSyncLost = 1'b1;
    ev.frameTick = 1'b0;
    i_line.set_levels(ev);
    fsl = 0;
    repeat (3) begin
      i_line.pulse('{frameTick: 1'b1, default: '0});
      fsl++;
    end
    rd(OFS_FRAME_SYNC_LOSS);
    i_line.set_levels('0);
    $display("test counters done");
    for (int b = 7; b > 0; b--) begin
      ev = '0;
      case (b)
        7: ev.remoteAlarmBit = 1'b1;
        6: ev.allOnes = 1'b1;
        5: ev.slot16AllOnes = 1'b1;
        4: ev.signalAbsent = 1'b1;
        3: ev.auxPattern = 1'b1;
        2: ev.multiframeAlarm = 1'b1;
        default: ev.elasticSlip = 1'b1;
      endcase
      i_line.pulse(ev);
      repeat (b * 5) @(posedge clk);
      latch = latch | (1 << b);
      rd(OFS_ALARM_LATCH);
      rd(OFS_ALARM_LATCH);
    end
    $display("test alarm latch done");
    foreach (runs[i]) begin
      ev = '0;
      ev.remoteAlarmBit = 1'b1;
      ev.eBitLow = 1'b1;
      i_line.set_levels(ev);
      repeat (runs[i]) @(posedge clk);
      longNow = (runs[i] > RMIN) ? 1 : 0;
      rd(OFS_REMOTE_ALARM);
      i_line.set_levels('0);
      longNow = 0;
      win = (runs[i] > RMIN && runs[i] < RMAX) ? 1 : 0;
      repeat (3) @(posedge clk);
      rd(OFS_REMOTE_ALARM);
      rd(OFS_REMOTE_ALARM);
      latch = latch | (1 << ALM_FAR_END);
      rd(OFS_ALARM_LATCH);
    end
    $display("test alarm runs done");
    tallyAndFinish();
  end
endmodule : e1_rx_perf_monitor_status_test
